// ### hdl/i2cra_control.sv
// Contract
// - SDA output lags SCL by 240, 280, 320 or 360 ns per 2-bit setting; the code rounds up to 250, 300, 350 or 400 ns.
// - Lock bit set rejects register writes arriving over the control channel.
// - Lock never blocks remote access to targets on the local bus.
// - Watchdog on, SDA high and bus quiet about 1 s (1 ms with the speedup bit set): bus is free.
// - Watchdog on, SDA stuck low and bus quiet: drive 9 SCL pulses.
// - Watchdog-disable bit 0 runs the watchdog, 1 stops it.
// - Deserializer address in bits 7:1; zero blocks access to the deserializer.
// - After receive lock, deserializer address loads from the channel unless frozen.
// - Freeze bit 1 keeps the written address; 0 allows auto-loading.
// - Transactions to alias 0 get the target 0 address before forwarding.
// - Target or alias field zero blocks target 0; both reset to zero.
// - Secondary port select steers address, freeze, target and alias accesses.
// - Alias hits forward only while pass-through is enabled, off by default.
`timescale 1ns/10ps
module i2cra_control
  import i2cra_pkg::*;
#(
  parameter int FREE_CYC = WDOG_TIMEOUT_CYC,
  parameter int FAST_CYC = WDOG_FAST_CYC,
  parameter int HALF_CYC = RECOVERY_HALF_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Register access
  input wire logic regReq,
  input i2cra_reg_req_t regCmd,
  output logic regAck,
  output logic regRejected,
  output logic [7:0] regRdata,
  // Link port state
  input wire logic secondaryPortSelect,
  input wire logic [NUM_PORTS-1:0] rxLock,
  input wire logic [NUM_PORTS-1:0] passThroughEn,
  // Deserializer address from the control channel
  input wire logic idLoad,
  input wire logic idLoadPort,
  input wire logic [6:0] idLoadAddr,
  // Transaction translation
  input wire logic txnReq,
  input i2cra_txn_t txnIn,
  output logic fwdValid,
  output i2cra_txn_t fwdTxn,
  output logic txnBlocked,
  // SDA output delay
  input wire logic sdaOeRaw,
  output logic sdaOeDelayed,
  // Bus pins and watchdog
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sclOe,
  output logic busFree
);

  localparam int PIPE_W = SDA_DLY_MAX_CYC - 1;

  if (NUM_PORTS != 2) begin : gChk
    $error("i2cra_control: exactly two link ports are supported");
  end

  logic [1:0] sdaDly_r, sdaDly_nxt;
  logic lock_r, lock_nxt, speedup_r, speedup_nxt, wdogDis_r, wdogDis_nxt;
  logic [6:0] deserAddr_r [NUM_PORTS], deserAddr_nxt [NUM_PORTS];
  logic freeze_r [NUM_PORTS], freeze_nxt [NUM_PORTS];
  logic [6:0] tgtAddr_r [NUM_PORTS], tgtAddr_nxt [NUM_PORTS];
  logic [6:0] aliasAddr_r [NUM_PORTS], aliasAddr_nxt [NUM_PORTS];
  logic regAck_r, regAck_nxt, regRejected_r, regRejected_nxt;
  logic [7:0] regRdata_r, regRdata_nxt;
  logic wrOk;
  logic sel;

  // Register file
  always_comb begin
    sdaDly_nxt = sdaDly_r;
    lock_nxt = lock_r;
    speedup_nxt = speedup_r;
    wdogDis_nxt = wdogDis_r;
    deserAddr_nxt = deserAddr_r;
    freeze_nxt = freeze_r;
    tgtAddr_nxt = tgtAddr_r;
    aliasAddr_nxt = aliasAddr_r;
    regAck_nxt = regReq;
    regRejected_nxt = 1'b0;
    regRdata_nxt = regRdata_r;
    sel = secondaryPortSelect;
    // Remote writes are refused while the lock bit is set; local writes always land
    wrOk = regReq && regCmd.write && !(regCmd.remote && lock_r);
    if (regReq && regCmd.write && regCmd.remote && lock_r) begin
      regRejected_nxt = 1'b1;
    end
    if (wrOk) begin
      unique case (regCmd.addr)
        ADDR_I2C_CONTROL: begin
          sdaDly_nxt = regCmd.wdata[CTRL_SDA_DLY_MSB:CTRL_SDA_DLY_LSB];
          lock_nxt = regCmd.wdata[CTRL_LOCK_BIT];
          speedup_nxt = regCmd.wdata[CTRL_SPEEDUP_BIT];
          wdogDis_nxt = regCmd.wdata[CTRL_WDOG_DIS_BIT];
        end
        ADDR_REMOTE_DESER: begin
          deserAddr_nxt[sel] = regCmd.wdata[ID_ADDR_MSB:ID_ADDR_LSB];
          freeze_nxt[sel] = regCmd.wdata[ID_FREEZE_BIT];
        end
        ADDR_TARGET_ADDR0: tgtAddr_nxt[sel] = regCmd.wdata[ID_ADDR_MSB:ID_ADDR_LSB];
        ADDR_TARGET_ALIAS0: aliasAddr_nxt[sel] = regCmd.wdata[ID_ADDR_MSB:ID_ADDR_LSB];
        default: ;
      endcase
    end
    // Channel load wins over a software write to the same field unless frozen
    if (idLoad && rxLock[idLoadPort] && !freeze_r[idLoadPort]) begin
      deserAddr_nxt[idLoadPort] = idLoadAddr;
    end
    if (regReq && !regCmd.write) begin
      unique case (regCmd.addr)
        ADDR_I2C_CONTROL: begin
          regRdata_nxt = 8'h00;
          regRdata_nxt[CTRL_SDA_DLY_MSB:CTRL_SDA_DLY_LSB] = sdaDly_r;
          regRdata_nxt[CTRL_LOCK_BIT] = lock_r;
          regRdata_nxt[CTRL_SPEEDUP_BIT] = speedup_r;
          regRdata_nxt[CTRL_WDOG_DIS_BIT] = wdogDis_r;
        end
        ADDR_REMOTE_DESER: regRdata_nxt = {deserAddr_r[sel], freeze_r[sel]};
        ADDR_TARGET_ADDR0: regRdata_nxt = {tgtAddr_r[sel], 1'b0};
        ADDR_TARGET_ALIAS0: regRdata_nxt = {aliasAddr_r[sel], 1'b0};
        default: regRdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      sdaDly_r <= CTRL_RESET[CTRL_SDA_DLY_MSB:CTRL_SDA_DLY_LSB];
      lock_r <= CTRL_RESET[CTRL_LOCK_BIT];
      speedup_r <= CTRL_RESET[CTRL_SPEEDUP_BIT];
      wdogDis_r <= CTRL_RESET[CTRL_WDOG_DIS_BIT];
      for (int i = 0; i < NUM_PORTS; i++) begin
        deserAddr_r[i] <= DESER_RESET[ID_ADDR_MSB:ID_ADDR_LSB];
        freeze_r[i] <= DESER_RESET[ID_FREEZE_BIT];
        tgtAddr_r[i] <= TARGET_RESET[ID_ADDR_MSB:ID_ADDR_LSB];
        aliasAddr_r[i] <= ALIAS_RESET[ID_ADDR_MSB:ID_ADDR_LSB];
      end
      regAck_r <= 1'b0;
      regRejected_r <= 1'b0;
      regRdata_r <= 8'h00;
    end else begin
      sdaDly_r <= sdaDly_nxt;
      lock_r <= lock_nxt;
      speedup_r <= speedup_nxt;
      wdogDis_r <= wdogDis_nxt;
      deserAddr_r <= deserAddr_nxt;
      freeze_r <= freeze_nxt;
      tgtAddr_r <= tgtAddr_nxt;
      aliasAddr_r <= aliasAddr_nxt;
      regAck_r <= regAck_nxt;
      regRejected_r <= regRejected_nxt;
      regRdata_r <= regRdata_nxt;
    end
  end

  // Address translation toward the control channel
  logic fwdValid_r, fwdValid_nxt, txnBlocked_r, txnBlocked_nxt;
  i2cra_txn_t fwdTxn_r, fwdTxn_nxt;
  logic deserHit, aliasHit;
  logic tp;

  always_comb begin
    tp = txnIn.port;
    deserHit = (deserAddr_r[tp] != 7'h00) && (txnIn.addr == deserAddr_r[tp]);
    aliasHit = passThroughEn[tp] && (aliasAddr_r[tp] != 7'h00)
               && (tgtAddr_r[tp] != 7'h00) && (txnIn.addr == aliasAddr_r[tp]);
    fwdValid_nxt = 1'b0;
    txnBlocked_nxt = 1'b0;
    fwdTxn_nxt = fwdTxn_r;
    if (txnReq) begin
      if (deserHit) begin
        fwdValid_nxt = 1'b1;
        fwdTxn_nxt = txnIn;
      end else if (aliasHit) begin
        fwdValid_nxt = 1'b1;
        fwdTxn_nxt = txnIn;
        fwdTxn_nxt.addr = tgtAddr_r[tp];
      end else begin
        txnBlocked_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      fwdValid_r <= 1'b0;
      txnBlocked_r <= 1'b0;
      fwdTxn_r <= '0;
    end else begin
      fwdValid_r <= fwdValid_nxt;
      txnBlocked_r <= txnBlocked_nxt;
      fwdTxn_r <= fwdTxn_nxt;
    end
  end

  // SDA delay line; the output flop adds the last cycle
  logic [PIPE_W-1:0] sdaPipe_r, sdaPipe_nxt;
  logic sdaOut_r, sdaOut_nxt;
  logic [3:0] tap;

  always_comb begin
    sdaPipe_nxt = {sdaPipe_r[PIPE_W-2:0], sdaOeRaw};
    tap = sdaDelayCycles(sdaDly_r) - 4'h2;
    sdaOut_nxt = sdaPipe_r[tap[2:0]];
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      sdaPipe_r <= '0;
      sdaOut_r <= 1'b0;
    end else begin
      sdaPipe_r <= sdaPipe_nxt;
      sdaOut_r <= sdaOut_nxt;
    end
  end

  i2cra_bus_watchdog #(
    .FREE_CYC(FREE_CYC),
    .FAST_CYC(FAST_CYC),
    .HALF_CYC(HALF_CYC),
    .PULSES(RECOVERY_PULSES)
  ) uWdog (
    .mclk(mclk),
    .srst(srst),
    .enable(!wdogDis_r),
    .speedup(speedup_r),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .sclOe(sclOe),
    .busFree(busFree)
  );

  assign regAck = regAck_r;
  assign regRejected = regRejected_r;
  assign regRdata = regRdata_r;
  assign fwdValid = fwdValid_r;
  assign fwdTxn = fwdTxn_r;
  assign txnBlocked = txnBlocked_r;
  assign sdaOeDelayed = sdaOut_r;

endmodule // i2cra_control

// ### pkg/i2cra_pkg.sv
package i2cra_pkg;

  // System clock
  localparam int CLK_PERIOD_NS = 50;
  localparam int NUM_PORTS = 2;

  // Register offsets
  localparam logic [7:0] ADDR_I2C_CONTROL = 8'h05;
  localparam logic [7:0] ADDR_REMOTE_DESER = 8'h06;
  localparam logic [7:0] ADDR_TARGET_ADDR0 = 8'h07;
  localparam logic [7:0] ADDR_TARGET_ALIAS0 = 8'h08;

  // Field positions
  localparam int CTRL_SDA_DLY_LSB = 3;
  localparam int CTRL_SDA_DLY_MSB = 4;
  localparam int CTRL_LOCK_BIT = 2;
  localparam int CTRL_SPEEDUP_BIT = 1;
  localparam int CTRL_WDOG_DIS_BIT = 0;
  localparam int ID_ADDR_LSB = 1;
  localparam int ID_ADDR_MSB = 7;
  localparam int ID_FREEZE_BIT = 0;

  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DESER_RESET = 8'h00;
  localparam logic [7:0] TARGET_RESET = 8'h00;
  localparam logic [7:0] ALIAS_RESET = 8'h00;

  // SDA output delay, nominal figures
  localparam int SDA_DLY_BASE_NS = 240;
  localparam int SDA_DLY_STEP_NS = 40;
  localparam int SDA_DLY_MAX_NS = 360;
  localparam int SDA_DLY_MAX_CYC = (SDA_DLY_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Bus watchdog timing
  localparam int WDOG_TIMEOUT_MS = 1000;
  localparam int WDOG_TIMEOUT_CYC = WDOG_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int WDOG_FAST_US = 1000;
  localparam int WDOG_FAST_CYC = WDOG_FAST_US * 1000 / CLK_PERIOD_NS;
  localparam int RECOVERY_HALF_NS = 5000;
  localparam int RECOVERY_HALF_CYC = (RECOVERY_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVERY_PULSES = 9;

  // Register access command
  typedef struct packed {
    logic write;
    logic remote;
    logic [7:0] addr;
    logic [7:0] wdata;
  } i2cra_reg_req_t;

  // Transaction header on its way to the control channel
  typedef struct packed {
    logic [6:0] addr;
    logic rnw;
    logic port;
  } i2cra_txn_t;

  // Cycles of SCL-to-SDA delay for a 2-bit setting, rounded up
  function automatic logic [3:0] sdaDelayCycles(input logic [1:0] sel);
    int ns;
    ns = SDA_DLY_BASE_NS + SDA_DLY_STEP_NS * int'(sel);
    return 4'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  endfunction

endpackage

// ### hdl/i2cra_bus_watchdog.sv
`timescale 1ns/10ps
module i2cra_bus_watchdog
  import i2cra_pkg::*;
#(
  parameter int FREE_CYC = WDOG_TIMEOUT_CYC,
  parameter int FAST_CYC = WDOG_FAST_CYC,
  parameter int HALF_CYC = RECOVERY_HALF_CYC,
  parameter int PULSES = RECOVERY_PULSES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Control
  input wire logic enable,
  input wire logic speedup,
  // Bus pins
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sclOe,
  // Status
  output logic busFree
);

  localparam int CW = $clog2(FREE_CYC + 1);
  localparam int HW = $clog2(HALF_CYC + 1);
  localparam int PW = $clog2(PULSES + 1);

  if (FREE_CYC < 2 || FAST_CYC < 2 || FAST_CYC > FREE_CYC
      || HALF_CYC < 1 || PULSES < 1) begin : gChk
    $error("i2cra_bus_watchdog: bad timing parameters");
  end

  typedef enum logic [1:0] {WD_WATCH, WD_LOW, WD_HIGH} i2cra_wd_state_t;

  logic [2:0] sclSync_r, sclSync_nxt, sdaSync_r, sdaSync_nxt;
  logic sclF_r, sclF_nxt, sdaF_r, sdaF_nxt;
  logic [CW-1:0] idleCnt_r, idleCnt_nxt;
  logic [HW-1:0] halfCnt_r, halfCnt_nxt;
  logic [PW-1:0] pulseCnt_r, pulseCnt_nxt;
  i2cra_wd_state_t state_r, state_nxt;
  logic sclOe_r, sclOe_nxt, busFree_r, busFree_nxt;
  logic activity;
  logic [CW-1:0] limit;

  always_comb begin
    sclSync_nxt = {sclSync_r[1:0], sclIn};
    sdaSync_nxt = {sdaSync_r[1:0], sdaIn};
    // Filtered level moves once the second and third stages agree
    sclF_nxt = (sclSync_r[1] == sclSync_r[2]) ? sclSync_r[2] : sclF_r;
    sdaF_nxt = (sdaSync_r[1] == sdaSync_r[2]) ? sdaSync_r[2] : sdaF_r;
    activity = (sclF_nxt != sclF_r) || (sdaF_nxt != sdaF_r);
    limit = speedup ? CW'(FAST_CYC - 1) : CW'(FREE_CYC - 1);
    idleCnt_nxt = idleCnt_r;
    halfCnt_nxt = halfCnt_r;
    pulseCnt_nxt = pulseCnt_r;
    state_nxt = state_r;
    sclOe_nxt = 1'b0;
    busFree_nxt = busFree_r;
    unique case (state_r)
      WD_WATCH: begin
        if (!enable) begin
          idleCnt_nxt = '0;
          busFree_nxt = 1'b0;
        end else if (activity) begin
          idleCnt_nxt = '0;
          busFree_nxt = 1'b0;
        end else if (idleCnt_r >= limit) begin
          if (sdaF_r) begin
            busFree_nxt = 1'b1;
          end else begin
            state_nxt = WD_LOW;
            sclOe_nxt = 1'b1;
            halfCnt_nxt = '0;
            pulseCnt_nxt = '0;
            idleCnt_nxt = '0;
          end
        end else begin
          idleCnt_nxt = idleCnt_r + CW'(1);
        end
      end
      WD_LOW: begin
        sclOe_nxt = 1'b1;
        busFree_nxt = 1'b0;
        if (halfCnt_r == HW'(HALF_CYC - 1)) begin
          halfCnt_nxt = '0;
          sclOe_nxt = 1'b0;
          state_nxt = WD_HIGH;
        end else begin
          halfCnt_nxt = halfCnt_r + HW'(1);
        end
      end
      WD_HIGH: begin
        if (halfCnt_r == HW'(HALF_CYC - 1)) begin
          halfCnt_nxt = '0;
          if (pulseCnt_r == PW'(PULSES - 1)) begin
            state_nxt = WD_WATCH;
            idleCnt_nxt = '0;
          end else begin
            pulseCnt_nxt = pulseCnt_r + PW'(1);
            sclOe_nxt = 1'b1;
            state_nxt = WD_LOW;
          end
        end else begin
          halfCnt_nxt = halfCnt_r + HW'(1);
        end
      end
      // Unused fourth code falls back to watching
      default: begin
        state_nxt = WD_WATCH;
        idleCnt_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      sclSync_r <= 3'h7;
      sdaSync_r <= 3'h7;
      sclF_r <= 1'b1;
      sdaF_r <= 1'b1;
      idleCnt_r <= '0;
      halfCnt_r <= '0;
      pulseCnt_r <= '0;
      state_r <= WD_WATCH;
      sclOe_r <= 1'b0;
      busFree_r <= 1'b0;
    end else begin
      sclSync_r <= sclSync_nxt;
      sdaSync_r <= sdaSync_nxt;
      sclF_r <= sclF_nxt;
      sdaF_r <= sdaF_nxt;
      idleCnt_r <= idleCnt_nxt;
      halfCnt_r <= halfCnt_nxt;
      pulseCnt_r <= pulseCnt_nxt;
      state_r <= state_nxt;
      sclOe_r <= sclOe_nxt;
      busFree_r <= busFree_nxt;
    end
  end

  assign sclOe = sclOe_r;
  assign busFree = busFree_r;

endmodule // i2cra_bus_watchdog

// ### tb/i2cra_assertions.sv
`timescale 1ns/10ps
module i2cra_assertions
  import i2cra_pkg::*;
#(
  parameter int HALF_CYC = RECOVERY_HALF_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Register port
  input wire logic regReq,
  input i2cra_reg_req_t regCmd,
  input wire logic regAck,
  input wire logic regRejected,
  // Translation
  input wire logic txnReq,
  input i2cra_txn_t txnIn,
  input wire logic fwdValid,
  input i2cra_txn_t fwdTxn,
  input wire logic txnBlocked,
  // Pins
  input wire logic sdaOeRaw,
  input wire logic sdaOeDelayed,
  input wire logic sdaIn,
  input wire logic sclOe,
  input wire logic busFree
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  logic [7:0] ctl_r, ctl_nxt;
  int hiCnt_r, hiCnt_nxt;
  logic ctlWr;
  // Shadow of the control register, locked remote writes excluded
  assign ctlWr = regReq && regCmd.write && regCmd.addr == ADDR_I2C_CONTROL
    && !(regCmd.remote && ctl_r[CTRL_LOCK_BIT]);
  always_comb begin
    ctl_nxt = ctlWr ? regCmd.wdata : ctl_r;
    hiCnt_nxt = sclOe ? hiCnt_r + 1 : 0;
  end
  always_ff @(posedge mclk) begin
    ctl_r <= srst ? CTRL_RESET : ctl_nxt;
    hiCnt_r <= srst ? 0 : hiCnt_nxt;
  end
  a_ack_next: assert property (regReq |=> regAck)
    else $error("register request not acknowledged");
  a_remote_refused: assert property (regReq && regCmd.write && regCmd.remote
    && ctl_r[CTRL_LOCK_BIT] |=> regRejected) else $error("locked remote write taken");
  a_local_taken: assert property (regReq && !(regCmd.write && regCmd.remote)
    |=> !regRejected) else $error("access wrongly refused");
  a_txn_answer: assert property (txnReq |=> fwdValid != txnBlocked)
    else $error("transaction without single answer");
  a_fwd_cause: assert property (fwdValid || txnBlocked |-> $past(txnReq))
    else $error("answer without transaction");
  a_fwd_dir: assert property (fwdValid |-> fwdTxn.rnw == $past(txnIn.rnw)
    && fwdTxn.port == $past(txnIn.port)) else $error("direction or port altered");
  a_sda_base: assert property (ctl_r[4:3] == 2'h0
    |-> sdaOeDelayed == $past(sdaOeRaw, 5)) else $error("base sda delay wrong");
  a_sda_max: assert property (ctl_r[4:3] == 2'h3
    |-> sdaOeDelayed == $past(sdaOeRaw, 8)) else $error("max sda delay wrong");
  a_pulse_half: assert property ($fell(sclOe) |-> hiCnt_r == HALF_CYC)
    else $error("recovery pulse length wrong");
  a_wdog_off: assert property (ctl_r[0] && $past(ctl_r[0])
    |-> !$rose(sclOe) && !$rose(busFree)) else $error("watchdog acts while off");
  a_free_high: assert property ($rose(busFree) |-> $past(sdaIn, 3))
    else $error("bus free with data low");
  c_refused: cover property (regRejected);
  c_forward: cover property (fwdValid);
  c_pulse: cover property ($fell(sclOe));
  c_free: cover property ($rose(busFree));
endmodule // i2cra_assertions

bind i2cra_control i2cra_assertions #(.HALF_CYC(HALF_CYC)) u_chk (
  .mclk(mclk), .srst(srst), .regReq(regReq), .regCmd(regCmd), .regAck(regAck),
  .regRejected(regRejected), .txnReq(txnReq), .txnIn(txnIn), .fwdValid(fwdValid),
  .fwdTxn(fwdTxn), .txnBlocked(txnBlocked), .sdaOeRaw(sdaOeRaw),
  .sdaOeDelayed(sdaOeDelayed), .sdaIn(sdaIn), .sclOe(sclOe), .busFree(busFree)
);

// ### tb/i2cra_bus_model.sv
`timescale 1ns/10ps
module i2cra_bus_model (
  // Device side
  input wire logic sclOe,
  // Scenario control
  input wire logic holdSdaLow,
  input wire logic hostSclLow,
  // Resolved wires
  output logic sclIn,
  output logic sdaIn
);
  // Both lines pulled up; any party pulling low wins
  assign sclIn = !(sclOe || hostSclLow);
  assign sdaIn = !holdSdaLow;
endmodule // i2cra_bus_model

// ### tb/i2c_remote_alias_control_test.sv
`timescale 1ns/10ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
module i2c_remote_alias_control_test
  import i2cra_pkg::*;
;
  logic mclk = 1'b0, srst = 1'b1, regReq = 1'b0, secondaryPortSelect = 1'b0;
  i2cra_reg_req_t regCmd = '0;
  logic regAck, regRejected, fwdValid, txnBlocked, sdaOeDelayed, sclIn, sdaIn, sclOe, busFree;
  logic [7:0] regRdata;
  logic [1:0] rxLock = 2'h0, passThroughEn = 2'h0;
  logic idLoad = 1'b0, idLoadPort = 1'b0, txnReq = 1'b0, sdaOeRaw = 1'b0;
  logic holdSdaLow = 1'b0, hostSclLow = 1'b0;
  logic [6:0] idLoadAddr = 7'h00;
  i2cra_txn_t txnIn = '0, fwdTxn;
  int n_fail = 0, n_checks = 0, seed = 70229;
  logic [7:0] ctl = 8'h00, rd = 8'h00;
  logic [7:0] des [2] = '{8'h00, 8'h00}, tgt [2] = '{8'h00, 8'h00}, ali [2] = '{8'h00, 8'h00};

  always #(CLK_PERIOD_NS / 2) mclk = ~mclk;

  i2cra_control #(.FREE_CYC(50), .FAST_CYC(20), .HALF_CYC(2)) u_dut (
    .mclk(mclk), .srst(srst), .regReq(regReq), .regCmd(regCmd), .regAck(regAck),
    .regRejected(regRejected), .regRdata(regRdata),
    .secondaryPortSelect(secondaryPortSelect), .rxLock(rxLock),
    .passThroughEn(passThroughEn), .idLoad(idLoad), .idLoadPort(idLoadPort),
    .idLoadAddr(idLoadAddr), .txnReq(txnReq), .txnIn(txnIn), .fwdValid(fwdValid),
    .fwdTxn(fwdTxn), .txnBlocked(txnBlocked), .sdaOeRaw(sdaOeRaw),
    .sdaOeDelayed(sdaOeDelayed), .sclIn(sclIn), .sdaIn(sdaIn), .sclOe(sclOe),
    .busFree(busFree));
  i2cra_bus_model u_bus (.sclOe(sclOe), .holdSdaLow(holdSdaLow), .hostSclLow(hostSclLow),
    .sclIn(sclIn), .sdaIn(sdaIn));

  function automatic logic [7:0] peek(input logic [7:0] a, input logic p);
    case (a)
      8'h05: return ctl;
      8'h06: return des[p];
      8'h07: return tgt[p];
      8'h08: return ali[p];
      default: return 8'h00;
    endcase
  endfunction

  task automatic reg_op(input logic w, rem, input logic [7:0] a, d, input logic p);
    logic rej;
    @(posedge mclk);
    #1;
    secondaryPortSelect = p;
    regReq = 1'b1;
    regCmd = '{w, rem, a, d};
    rej = w && rem && ctl[2];
    if (w && !rej) begin
      case (a)
        8'h05: ctl = d & 8'h1F;
        8'h06: des[p] = d;
        8'h07: tgt[p] = d & 8'hFE;
        8'h08: ali[p] = d & 8'hFE;
        default: ;
      endcase
    end
    if (!w) rd = peek(a, p);
    @(posedge mclk);
    #1;
    regReq = 1'b0;
    `CHK(regAck, 1'b1)
    `CHK(regRejected, rej)
    `CHK(regRdata, rd)
  endtask

  task automatic txn(input logic [6:0] a, input logic rnw, p);
    logic hitD, hitA;
    i2cra_txn_t e;
    @(posedge mclk);
    #1;
    txnReq = 1'b1;
    txnIn = '{a, rnw, p};
    hitD = des[p][7:1] != 0 && a == des[p][7:1];
    hitA = passThroughEn[p] && ali[p][7:1] != 0 && tgt[p][7:1] != 0 && a == ali[p][7:1];
    e = '{hitD ? a : tgt[p][7:1], rnw, p};
    @(posedge mclk);
    #1;
    txnReq = 1'b0;
    `CHK(fwdValid, hitD || hitA)
    `CHK(txnBlocked, !(hitD || hitA))
    if (hitD || hitA) `CHK(fwdTxn, e)
  endtask

  task automatic id_load(input logic p, input logic [6:0] a);
    @(posedge mclk);
    #1;
    idLoad = 1'b1;
    idLoadPort = p;
    idLoadAddr = a;
    if (rxLock[p] && !des[p][0]) des[p] = {a, 1'b0};
    @(posedge mclk);
    #1;
    idLoad = 1'b0;
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    #(CLK_PERIOD_NS * 20000);
    n_fail++;
    tally_and_finish();
  end

  initial begin
    logic [6:0] a7;
    int k, pulses, prev;
    repeat (10) @(posedge mclk);
    #1 srst = 1'b0;
    for (int i = 0; i < 12; i++) reg_op(1'b0, 1'b0, 8'(4 + i % 6), 8'h00, 1'(i / 6));
    reg_op(1'b1, 1'b0, 8'h09, 8'hFF, 1'b0);
    reg_op(1'b1, 1'b0, 8'h06, 8'h50, 1'b0);
    reg_op(1'b1, 1'b0, 8'h08, 8'h60, 1'b0);
    reg_op(1'b1, 1'b0, 8'h07, 8'h44, 1'b0);
    reg_op(1'b1, 1'b0, 8'h08, 8'h62, 1'b1);
    reg_op(1'b1, 1'b0, 8'h07, 8'h46, 1'b1);
    for (int i = 0; i < 4; i++) reg_op(1'b0, 1'b0, 8'(5 + i), 8'h00, 1'(i % 2));
    txn(7'h28, 1'b1, 1'b0);
    txn(7'h30, 1'b0, 1'b0);
    passThroughEn = 2'h3;
    txn(7'h30, 1'b1, 1'b0);
    txn(7'h31, 1'b0, 1'b1);
    txn(7'h28, 1'b0, 1'b1);
    reg_op(1'b1, 1'b0, 8'h05, 8'h04, 1'b0);
    reg_op(1'b1, 1'b1, 8'h07, 8'h22, 1'b0);
    reg_op(1'b0, 1'b1, 8'h07, 8'h00, 1'b0);
    reg_op(1'b1, 1'b1, 8'h05, 8'h00, 1'b0);
    txn(7'h30, 1'b0, 1'b0);
    reg_op(1'b1, 1'b0, 8'h05, 8'h00, 1'b0);
    reg_op(1'b1, 1'b1, 8'h07, 8'h44, 1'b0);
    reg_op(1'b1, 1'b0, 8'h08, 8'h00, 1'b1);
    txn(7'h31, 1'b1, 1'b1);
    txn(7'h00, 1'b0, 1'b1);
    for (int i = 0; i < 6; i++) begin
      a7 = 7'($random(seed) | 1);
      reg_op(1'b1, 1'b0, 8'h08, {a7, 1'b0}, 1'b0);
      reg_op(1'b1, 1'b0, 8'h07, 8'($random(seed)), 1'b0);
      txn(a7, 1'($random(seed)), 1'b0);
    end
    rxLock = 2'h1;
    id_load(1'b0, 7'h3A);
    id_load(1'b1, 7'h3B);
    reg_op(1'b1, 1'b0, 8'h06, 8'h91, 1'b0);
    id_load(1'b0, 7'h11);
    rxLock = 2'h3;
    id_load(1'b1, 7'h3B);
    for (int i = 0; i < 2; i++) reg_op(1'b0, 1'b0, 8'h06, 8'h00, 1'(i));
    txn(7'h48, 1'b1, 1'b0);
    for (int s = 0; s < 4; s++) begin
      reg_op(1'b1, 1'b0, 8'h05, 8'(s << 3), 1'b0);
      sdaOeRaw = 1'b1;
      repeat (4 + s) @(posedge mclk);
      #1 `CHK(sdaOeDelayed, 1'b0)
      @(posedge mclk);
      #1 `CHK(sdaOeDelayed, 1'b1)
      sdaOeRaw = 1'b0;
      repeat (10) @(posedge mclk);
    end
    reg_op(1'b1, 1'b0, 8'h05, 8'h02, 1'b0);
    holdSdaLow = 1'b1;
    k = 0;
    while (!sclOe && k < 100) begin
      @(posedge mclk);
      #1 k++;
    end
    pulses = 1;
    repeat (45) begin
      prev = sclOe;
      @(posedge mclk);
      #1 if (sclOe && !prev) pulses++;
    end
    `CHK(pulses, 9)
    reg_op(1'b1, 1'b0, 8'h05, 8'h03, 1'b0);
    pulses = 0;
    repeat (100) begin
      @(posedge mclk);
      #1 if (sclOe) pulses++;
    end
    `CHK(pulses, 0)
    holdSdaLow = 1'b0;
    reg_op(1'b1, 1'b0, 8'h05, 8'h00, 1'b0);
    repeat (40) @(posedge mclk);
    #1 `CHK(busFree, 1'b0)
    repeat (30) @(posedge mclk);
    #1 `CHK(busFree, 1'b1)
    hostSclLow = 1'b1;
    repeat (8) @(posedge mclk);
    #1 `CHK(busFree, 1'b0)
    hostSclLow = 1'b0;
    tally_and_finish();
  end
endmodule // i2c_remote_alias_control_test
